// ==== logic/prs_cfg.svh ====
// Register map, field positions, reset values and timing counts for the reference switch
//
// Behaviour
// - Register 0x01A bit 5 puts input A, bit 6 input B, in CMOS mode
// - Differential receiver off when not selected or first PLL powered down
// - CMOS buffer off on PLL power-down, own power-down, or differential selected
// - Input B divider reuses A value unless 0x01C bit 7 is set
// - Each reference has its own integer divider, ratio 1 to 1023
// - Monitor judges divided references; its status drives switchover
// - Manual selection by software register or by the select pin
// - Automatic mode moves from A to B when A lost and B valid
// - Nonrevertive stays on B after A returns; back to A if B lost
// - Revertive returns to A as soon as A is present again
// - Both references absent puts the device in holdover
// - Holdover tristates the first charge pump by default
// - Holdover ends when a reference returns; first PLL resynchronises
// - 0x01C bit 6 forces charge pump to mid-supply during holdover
// - VCO band chosen by calibration started through register 0x0F3
// - Optional second-stage input doubler, enabled or bypassed
// - Feedback ratio is four times B plus A
// - B count 4 to 63, A count 0 to 3
// - VCO output divider ratios 4 through 11 only
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH

// Register indices; byte address is four times the index
`define PRS_IDX_REFCFG   10'h01a
`define PRS_IDX_MISC     10'h01c
`define PRS_IDX_VCOCTL   10'h0f3
`define PRS_IDX_RDIVA    10'h100
`define PRS_IDX_RDIVB    10'h101
`define PRS_IDX_SWCTL    10'h102
`define PRS_IDX_PLL2     10'h103
`define PRS_IDX_STATUS   10'h104

`define PRS_REFCFG_PDA   0
`define PRS_REFCFG_PDB   1
`define PRS_REFCFG_PLLPD 2
`define PRS_REFCFG_CMOSA 5
`define PRS_REFCFG_CMOSB 6
`define PRS_MISC_MIDCP   6
`define PRS_MISC_INDEPB  7
`define PRS_VCOCTL_CAL   1
`define PRS_SW_AUTO      0
`define PRS_SW_REVERT    1
`define PRS_SW_MANB      2
`define PRS_SW_USEPIN    3

`define PRS_RDIV_RST     10'h001
`define PRS_RDIV_MAX     10'h3ff
`define PRS_FB_PRESCALE  8'h04
`define PRS_FB_BMIN      6'h04
`define PRS_VDIV_MIN     4'h4
`define PRS_VDIV_MAX     4'hb
`define PRS_PLL2_RST     32'h0000_0410

`define PRS_CLK_MHZ      25
`define PRS_CAL_TIME_US  100
`define PRS_CAL_CYCLES   (`PRS_CAL_TIME_US * `PRS_CLK_MHZ)
`define PRS_MON_WINDOW   1024

`endif

// ==== logic/prs_pkg.sv ====
// Types shared by the reference switch design
package prs_pkg;
   typedef enum logic [1:0] {
      PRS_ON_A,
      PRS_ON_B,
      PRS_HOLD
   } prs_sw_state_t;
endpackage : prs_pkg

// ==== logic/prs_top.sv ====
// Reference select, dividers, monitor, switchover, holdover and second-stage settings
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "prs_cfg.svh"

module prs_top #(
   parameter int MON_WINDOW = `PRS_MON_WINDOW
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      pslverr,
   input  wire logic                 ref_input_a,
   input  wire logic                 ref_input_b,
   input  wire logic                 ref_sel,
   output logic                      ref_a_div_out,
   output logic                      ref_b_div_out,
   output logic                      ref_b_active,
   output logic                      holdover,
   output logic                      pll1_resync,
   output logic                      cp_tristate,
   output logic                      cp_midsupply,
   output logic                      diff_rx_pd,
   output logic                      cmos_a_pd,
   output logic                      cmos_b_pd,
   output logic                      cmos_a_mode,
   output logic                      cmos_b_mode,
   output logic                      doubler_en,
   output logic [7:0]                fb_ratio,
   output logic [3:0]                vco_div,
   output logic                      vco_cal_busy,
   output logic [3:0]                vco_band,
   output prs_pkg::prs_sw_state_t    sw_state
);
   import prs_pkg::*;

   localparam logic [15:0] CAL_CYC  = 16'(`PRS_CAL_CYCLES);
   localparam logic [15:0] MON_WIN  = 16'(MON_WINDOW);

   logic [7:0]  refcfg_q;
   logic [7:0]  misc_q;
   logic [7:0]  vcoctl_q;
   logic [9:0]  rdiva_q;
   logic [9:0]  rdivb_q;
   logic [3:0]  swctl_q;
   logic [31:0] pll2_q;
   logic        a_ok_q;
   logic        b_ok_q;

   // APB slave: answer one cycle after setup, so every transfer has no wait state
   logic [9:0]  idx;
   logic        mapped;
   logic        wr_en;
   logic [31:0] rd_d;

   assign idx   = paddr[11:2];
   assign wr_en = psel & penable & pready & pwrite & ~pslverr;

   always_comb begin
      mapped = 1'b1;
      rd_d   = 32'h0000_0000;
      case (idx)
         `PRS_IDX_REFCFG: rd_d = {24'h000000, refcfg_q};
         `PRS_IDX_MISC:   rd_d = {24'h000000, misc_q};
         `PRS_IDX_VCOCTL: rd_d = {24'h000000, vcoctl_q};
         `PRS_IDX_RDIVA:  rd_d = {22'h000000, rdiva_q};
         `PRS_IDX_RDIVB:  rd_d = {22'h000000, rdivb_q};
         `PRS_IDX_SWCTL:  rd_d = {28'h0000000, swctl_q};
         `PRS_IDX_PLL2:   rd_d = pll2_q;
         `PRS_IDX_STATUS: rd_d = {16'h0000, vco_band, 3'h0, vco_cal_busy,
                                  1'b0, holdover, ref_b_active, a_ok_q, b_ok_q,
                                  1'b0, sw_state};
         default:         mapped = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         if (psel && !penable) begin
            prdata <= (mapped && !pwrite) ? rd_d : 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refcfg_q <= 8'h00;
         misc_q   <= 8'h00;
         vcoctl_q <= 8'h00;
         rdiva_q  <= `PRS_RDIV_RST;
         rdivb_q  <= `PRS_RDIV_RST;
         swctl_q  <= 4'h0;
         pll2_q   <= `PRS_PLL2_RST;
      end else if (wr_en) begin
         case (idx)
            `PRS_IDX_REFCFG: refcfg_q <= pwdata[7:0];
            `PRS_IDX_MISC:   misc_q   <= pwdata[7:0];
            `PRS_IDX_VCOCTL: vcoctl_q <= pwdata[7:0];
            `PRS_IDX_RDIVA:  rdiva_q  <= pwdata[9:0];
            `PRS_IDX_RDIVB:  rdivb_q  <= pwdata[9:0];
            `PRS_IDX_SWCTL:  swctl_q  <= pwdata[3:0];
            `PRS_IDX_PLL2:   pll2_q   <= pwdata;
            default: ;
         endcase
      end
   end

   // Receiver power and input type
   logic pll1_pd;
   logic cmos_sel_a;
   logic cmos_sel_b;
   assign pll1_pd    = refcfg_q[`PRS_REFCFG_PLLPD];
   assign cmos_sel_a = refcfg_q[`PRS_REFCFG_CMOSA];
   assign cmos_sel_b = refcfg_q[`PRS_REFCFG_CMOSB];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         diff_rx_pd  <= 1'b1;
         cmos_a_pd   <= 1'b1;
         cmos_b_pd   <= 1'b1;
         cmos_a_mode <= 1'b0;
         cmos_b_mode <= 1'b0;
      end else begin
         cmos_a_mode <= cmos_sel_a;
         cmos_b_mode <= cmos_sel_b;
         // Shared receiver stays up while the first PLL is up and either input still runs differential
         diff_rx_pd  <= pll1_pd | (cmos_sel_a & cmos_sel_b);
         cmos_a_pd   <= pll1_pd | refcfg_q[`PRS_REFCFG_PDA] | ~cmos_sel_a;
         cmos_b_pd   <= pll1_pd | refcfg_q[`PRS_REFCFG_PDB] | ~cmos_sel_b;
      end
   end

   // Per-input dividers and monitors
   logic [9:0] div_val [2];
   logic [1:0] ref_in;
   logic [1:0] div_pulse;
   logic [1:0] ok_q;

   assign ref_in     = {ref_input_b, ref_input_a};
   assign div_val[0] = rdiva_q;
   assign div_val[1] = misc_q[`PRS_MISC_INDEPB] ? rdivb_q : rdiva_q;
   assign a_ok_q     = ok_q[0];
   assign b_ok_q     = ok_q[1];

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ref
         logic       prev_q;
         logic [9:0] cnt_q;
         logic       pulse_q;
         logic [15:0] idle_q;
         logic [9:0] lim;
         // A ratio of zero is taken as one so the divider never stalls
         assign lim = (div_val[g] == 10'h000) ? 10'h000 : div_val[g] - 10'h001;
         assign div_pulse[g] = pulse_q;

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               prev_q  <= 1'b0;
               cnt_q   <= 10'h000;
               pulse_q <= 1'b0;
            end else begin
               prev_q  <= ref_in[g];
               pulse_q <= 1'b0;
               if (ref_in[g] && !prev_q) begin
                  if (cnt_q >= lim) begin
                     cnt_q   <= 10'h000;
                     pulse_q <= 1'b1;
                  end else begin
                     cnt_q <= cnt_q + 10'h001;
                  end
               end
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               idle_q  <= 16'h0000;
               ok_q[g] <= 1'b0;
            end else if (pulse_q) begin
               idle_q  <= 16'h0000;
               ok_q[g] <= ~pll1_pd;
            end else if (idle_q >= MON_WIN - 16'h0001) begin
               ok_q[g] <= 1'b0;
            end else begin
               idle_q <= idle_q + 16'h0001;
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_a_div_out <= 1'b0;
         ref_b_div_out <= 1'b0;
      end else begin
         ref_a_div_out <= div_pulse[0];
         ref_b_div_out <= div_pulse[1];
      end
   end

   // Switchover
   logic auto_mode;
   logic revert;
   logic man_b;
   prs_sw_state_t nxt;

   assign auto_mode = swctl_q[`PRS_SW_AUTO];
   assign revert    = swctl_q[`PRS_SW_REVERT];
   assign man_b     = swctl_q[`PRS_SW_USEPIN] ? ref_sel : swctl_q[`PRS_SW_MANB];

   always_comb begin
      nxt = sw_state;
      if (!a_ok_q && !b_ok_q) begin
         nxt = PRS_HOLD;
      end else if (!auto_mode) begin
         nxt = man_b ? PRS_ON_B : PRS_ON_A;
      end else begin
         case (sw_state)
            PRS_ON_A: begin
               if (!a_ok_q && b_ok_q) nxt = PRS_ON_B;
            end
            PRS_ON_B: begin
               if (!b_ok_q && a_ok_q) nxt = PRS_ON_A;
               else if (revert && a_ok_q) nxt = PRS_ON_A;
            end
            PRS_HOLD: nxt = a_ok_q ? PRS_ON_A : PRS_ON_B;
            default:  nxt = PRS_ON_A;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_state     <= PRS_HOLD;
         ref_b_active <= 1'b0;
         holdover     <= 1'b1;
         pll1_resync  <= 1'b0;
         cp_tristate  <= 1'b1;
         cp_midsupply <= 1'b0;
      end else begin
         sw_state     <= nxt;
         ref_b_active <= (nxt == PRS_ON_B);
         holdover     <= (nxt == PRS_HOLD);
         pll1_resync  <= (sw_state == PRS_HOLD) && (nxt != PRS_HOLD);
         cp_tristate  <= (nxt == PRS_HOLD) && !misc_q[`PRS_MISC_MIDCP];
         cp_midsupply <= (nxt == PRS_HOLD) && misc_q[`PRS_MISC_MIDCP];
      end
   end

   // Second stage settings
   logic [5:0] b_cnt;
   logic [1:0] a_cnt;
   logic [3:0] vd_raw;
   assign b_cnt  = (pll2_q[5:0] < `PRS_FB_BMIN) ? `PRS_FB_BMIN : pll2_q[5:0];
   assign a_cnt  = pll2_q[9:8];
   assign vd_raw = pll2_q[15:12];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         doubler_en <= 1'b0;
         fb_ratio   <= 8'h10;
         vco_div    <= `PRS_VDIV_MIN;
      end else begin
         // Keeping the doubled rate under the detector limit is left to software
         doubler_en <= pll2_q[16];
         fb_ratio   <= 8'(`PRS_FB_PRESCALE * {2'b00, b_cnt}) + {6'h00, a_cnt};
         if (vd_raw < `PRS_VDIV_MIN)      vco_div <= `PRS_VDIV_MIN;
         else if (vd_raw > `PRS_VDIV_MAX) vco_div <= `PRS_VDIV_MAX;
         else                             vco_div <= vd_raw;
      end
   end

   // Calibration starts only on a 0 to 1 change of the calibrate bit
   logic        cal_prev_q;
   logic [15:0] cal_cnt_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_prev_q   <= 1'b0;
         cal_cnt_q    <= 16'h0000;
         vco_cal_busy <= 1'b0;
         vco_band     <= 4'h0;
      end else begin
         cal_prev_q <= vcoctl_q[`PRS_VCOCTL_CAL];
         if (vcoctl_q[`PRS_VCOCTL_CAL] && !cal_prev_q && !vco_cal_busy) begin
            vco_cal_busy <= 1'b1;
            cal_cnt_q    <= CAL_CYC - 16'h0001;
         end else if (vco_cal_busy) begin
            if (cal_cnt_q == 16'h0000) begin
               vco_cal_busy <= 1'b0;
               vco_band     <= fb_ratio[7:4];
            end else begin
               cal_cnt_q <= cal_cnt_q - 16'h0001;
            end
         end
      end
   end

endmodule : prs_top

// ==== testbench/prs_top_props.sv ====
// Port-level assertions for the reference switch
`timescale 1ns/1ps
module prs_props #(
   parameter int MON_WINDOW = 16
) (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pready,
   input wire logic               pslverr,
   input wire logic               ref_a_div_out,
   input wire logic               ref_b_active,
   input wire logic               holdover,
   input wire logic               pll1_resync,
   input wire logic               cp_tristate,
   input wire logic               cp_midsupply,
   input wire logic               diff_rx_pd,
   input wire logic               cmos_a_pd,
   input wire logic               cmos_a_mode,
   input wire logic               cmos_b_mode,
   input wire logic [7:0]         fb_ratio,
   input wire logic [3:0]         vco_div,
   input wire logic               vco_cal_busy,
   input prs_pkg::prs_sw_state_t  sw_state
);
   import prs_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_hold_state: assert property (holdover == (sw_state == PRS_HOLD))
      else $error("holdover flag disagrees with state");
   a_cp_hold: assert property ((cp_tristate | cp_midsupply) == holdover && !(cp_tristate && cp_midsupply))
      else $error("charge pump mode wrong");
   a_resync_exit: assert property (pll1_resync |-> $past(sw_state) == PRS_HOLD && sw_state != PRS_HOLD)
      else $error("resync without leaving holdover");
   a_b_active: assert property (ref_b_active == (sw_state == PRS_ON_B))
      else $error("active flag disagrees with state");
   a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("ready not a single cycle after setup");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_vco_range: assert property (vco_div >= 4'h4 && vco_div <= 4'hb)
      else $error("output divider out of range");
   a_fb_floor: assert property (fb_ratio >= 8'h10)
      else $error("feedback ratio below minimum");
   a_diff_pd: assert property (cmos_a_mode && cmos_b_mode |-> diff_rx_pd)
      else $error("receiver on with both inputs single ended");
   a_cmos_pd: assert property (!cmos_a_mode |-> cmos_a_pd)
      else $error("buffer on while differential selected");
   a_cal_hold: assert property ($rose(vco_cal_busy) |=> vco_cal_busy [*8])
      else $error("calibration ended too soon");
   a_div_pulse: assert property (ref_a_div_out |=> !ref_a_div_out)
      else $error("divider pulse too long");
endmodule : prs_props
bind prs_top prs_props #(.MON_WINDOW(MON_WINDOW)) prs_props_i (.*);

// ==== testbench/prs_ref_src.sv ====
// Two free-running reference sources that the bench can stop
`timescale 1ns/1ps
module prs_ref_src #(
   parameter int HALF_A = 200,
   parameter int HALF_B = 160
) (
   input  wire logic run_a,
   input  wire logic run_b,
   output logic      ref_input_a,
   output logic      ref_input_b
);
   initial ref_input_a = 1'b0;
   initial ref_input_b = 1'b0;
   // A stopped source sits low, as a dead oscillator would
   always #(HALF_A) ref_input_a = run_a & ~ref_input_a;
   always #(HALF_B) ref_input_b = run_b & ~ref_input_b;
endmodule : prs_ref_src

// ==== testbench/tb_prs_top.sv ====
// Self-checking bench for the reference switch and second-stage settings
`timescale 1ns/1ps
`include "prs_cfg.svh"
module tb_prs_top;
   import prs_pkg::*;
   typedef struct packed {
      logic [9:0]  idx;
      logic [31:0] d;
      logic [5:0]  f;
      logic [3:0]  v;
      logic [7:0]  n;
   } prs_row_t;
   logic          pclk, presetn, psel, penable, pwrite, ref_sel, run_a, run_b, err;
   logic [11:0]   paddr;
   logic [31:0]   pwdata, prdata, rd;
   logic          pready, pslverr, ref_input_a, ref_input_b, ref_a_div_out, ref_b_div_out;
   logic          ref_b_active, holdover, pll1_resync, cp_tristate, cp_midsupply;
   logic          diff_rx_pd, cmos_a_pd, cmos_b_pd, cmos_a_mode, cmos_b_mode;
   logic          doubler_en, vco_cal_busy;
   logic [7:0]    fb_ratio;
   logic [3:0]    vco_div, vco_band;
   prs_sw_state_t sw_state;
   int            fail_count, checks, rs, k, n;
   int            e [2];
   int            d [2];
   logic [4:0]    man [4] = '{5'h04, 5'h00, 5'h18, 5'h08};
   // Settings accumulate across registers: each row is judged with the last earlier write to every other register applied
   prs_row_t      rows [9] = '{
      '{`PRS_IDX_REFCFG, 32'h20, 6'b100010, 4'h4, 8'h40},
      '{`PRS_IDX_REFCFG, 32'h60, 6'b111000, 4'h4, 8'h40},
      '{`PRS_IDX_REFCFG, 32'h61, 6'b111100, 4'h4, 8'h40},
      '{`PRS_IDX_REFCFG, 32'h64, 6'b111110, 4'h4, 8'h40},
      '{`PRS_IDX_REFCFG, 32'h00, 6'b000110, 4'h4, 8'h40},
      '{`PRS_IDX_PLL2, 32'h1b33f, 6'b000111, 4'hb, 8'hff},
      '{`PRS_IDX_PLL2, 32'h3302, 6'b000110, 4'h4, 8'h13},
      '{`PRS_IDX_PLL2, 32'hc004, 6'b000110, 4'hb, 8'h10},
      '{`PRS_IDX_PLL2, 32'ha109, 6'b000110, 4'ha, 8'h25}};

   prs_top #(.MON_WINDOW(64)) prs_top_i (.*);
   prs_ref_src prs_ref_src_i (.*);

   always #20 pclk = ~pclk;
   always @(posedge ref_input_a) e[0]++;
   always @(posedge ref_input_b) e[1]++;
   // Counted mid-cycle so registered pulses have settled
   always @(negedge pclk) begin
      if (ref_a_div_out === 1'b1) d[0]++;
      if (ref_b_div_out === 1'b1) d[1]++;
      if (pll1_resync === 1'b1) rs++;
   end

   task results;
      if (fail_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results

   task chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk

   task apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, idx, 2'b00, wd};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // Ready, data and error are taken at the edge that ends the access
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      chk(n < 16, "no ready");
      if (n >= 16) results();
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb

   task wait_st(input prs_sw_state_t s);
      n = 0;
      while (sw_state !== s && n < 400) begin
         @(negedge pclk);
         n++;
      end
      chk(sw_state === s, "switch state");
      if (n >= 400) results();
   endtask : wait_st

   // Syncs on one divided pulse, then counts pulses over 30 input edges
   task meas(input int b, input int exp);
      int e0, d0;
      n = 0;
      d0 = d[b];
      while (d[b] == d0 && n < 200) begin
         @(negedge pclk);
         n++;
      end
      e0 = e[b];
      d0 = d[b];
      while (e[b] - e0 < 30 && n < 2000) begin
         @(negedge pclk);
         n++;
      end
      repeat (4) @(negedge pclk);
      chk(d[b] - d0 == exp && n < 2000, "divided pulse count");
   endtask : meas

   initial begin
      {pclk, presetn, psel, penable, pwrite, ref_sel, run_a, run_b} = '0;
      {paddr, pwdata} = '0;
      repeat (5) @(posedge pclk);
      @(negedge pclk);
      chk(holdover === 1'b1 && sw_state === PRS_HOLD && cp_tristate === 1'b1, "reset");
      @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         apb(1'b1, rows[i].idx, rows[i].d);
         repeat (2) @(negedge pclk);
         chk({cmos_a_mode, cmos_b_mode, diff_rx_pd, cmos_a_pd, cmos_b_pd, doubler_en,
              vco_div, fb_ratio} === {rows[i].f, rows[i].v, rows[i].n}, "config");
      end
      apb(1'b0, 10'h0ff, 32'h0);
      chk(err === 1'b1 && rd === 32'h0, "unmapped access");
      apb(1'b1, `PRS_IDX_RDIVA, 32'hffff_ffff);
      apb(1'b0, `PRS_IDX_RDIVA, 32'h0);
      chk(err === 1'b0 && rd === 32'h3ff, "divider field");
      apb(1'b1, `PRS_IDX_RDIVA, 32'h3);
      apb(1'b1, `PRS_IDX_RDIVB, 32'h5);
      {run_a, run_b} <= 2'b11;
      meas(0, 10);
      meas(1, 10);
      apb(1'b1, `PRS_IDX_MISC, 32'h80);
      meas(1, 6);
      foreach (man[i]) begin
         @(posedge pclk);
         ref_sel <= man[i][4];
         apb(1'b1, `PRS_IDX_SWCTL, {28'h0, man[i][3:0]});
         wait_st((man[i][2] || (man[i][3] && man[i][4])) ? PRS_ON_B : PRS_ON_A);
      end
      apb(1'b1, `PRS_IDX_SWCTL, 32'h1);
      run_a <= 1'b0;
      wait_st(PRS_ON_B);
      chk(ref_b_active === 1'b1, "b active");
      run_a <= 1'b1;
      repeat (200) @(negedge pclk);
      chk(sw_state === PRS_ON_B, "nonrevertive");
      run_b <= 1'b0;
      wait_st(PRS_ON_A);
      {run_a, run_b} <= 2'b01;
      wait_st(PRS_ON_B);
      apb(1'b1, `PRS_IDX_SWCTL, 32'h3);
      run_a <= 1'b1;
      wait_st(PRS_ON_A);
      {run_a, run_b} <= 2'b00;
      wait_st(PRS_HOLD);
      chk(cp_tristate === 1'b1 && cp_midsupply === 1'b0, "hold tristate");
      apb(1'b1, `PRS_IDX_MISC, 32'hc0);
      repeat (2) @(negedge pclk);
      chk(cp_midsupply === 1'b1 && cp_tristate === 1'b0, "hold midsupply");
      rs = 0;
      run_b <= 1'b1;
      wait_st(PRS_ON_B);
      @(negedge pclk);
      chk(rs == 1 && holdover === 1'b0 && cp_midsupply === 1'b0, "leave hold");
      apb(1'b0, `PRS_IDX_STATUS, 32'h0);
      chk(err === 1'b0 && rd === 32'h29, "status readback");
      apb(1'b1, `PRS_IDX_VCOCTL, 32'h2);
      n = 0;
      while (vco_cal_busy !== 1'b1 && n < 8) begin
         @(negedge pclk);
         n++;
      end
      k = 0;
      while (vco_cal_busy === 1'b1 && k < 3000) begin
         @(negedge pclk);
         k++;
      end
      repeat (2) @(negedge pclk);
      chk(k == `PRS_CAL_CYCLES && vco_band === 4'h2, "calibration");
      results();
   end
endmodule : tb_prs_top
